/* File: hw/irq_reset_pkg.sv */
/*
  Shared constants and carrier types for the interrupt and reset control block.
  Assumes a 10 MHz core clock and an 11-bit program address made of page and in-page word.
*/
package irq_reset_pkg;
  // program address layout
  localparam int unsigned PAGE_W  = 5;
  localparam int unsigned WORD_W  = 6;
  localparam int unsigned PC_W    = PAGE_W + WORD_W;
  localparam int unsigned STACK_DEPTH = 3;
  localparam int unsigned S_PORT_W    = 8;
  localparam int unsigned D_PORT_W    = 11;

  // fixed addresses
  localparam logic [PAGE_W-1:0] IRQ_PAGE   = 5'h0c;
  localparam logic [WORD_W-1:0] IRQ_WORD   = 6'h00;
  localparam logic [PC_W-1:0]   RESET_PC   = 11'h000;
  localparam logic [PC_W-1:0]   IRQ_VECTOR = {IRQ_PAGE, IRQ_WORD};

  // values after reset
  localparam logic                RESET_FLAG = 1'h0;
  localparam logic                RESET_ARM  = 1'h1;
  localparam logic                RESET_CPS  = 1'h0;
  localparam logic [S_PORT_W-1:0] RESET_S    = 8'h00;
  localparam logic [D_PORT_W-1:0] RESET_D    = 11'h000;

  // reference-input hold time before the alternative reset arms
  localparam int unsigned CLK_HZ       = 10_000_000;
  localparam int unsigned REF_HOLD_MS  = 50;
  localparam int unsigned REF_HOLD_CYC = (REF_HOLD_MS * (CLK_HZ / 1000));

  // one return stack level: address plus both skip flags
  typedef struct packed {
    logic [PC_W-1:0] pc;
    logic            skip;
    logic            chain;
  } stack_entry_t;

  // per-cycle commands from the instruction decoder
  typedef struct packed {
    logic                boundary;   // last state of the machine cycle
    logic                inc_pc;     // normal sequential advance
    logic                jump;       // load target
    logic                call;       // push and load target
    logic                ret;        // pop
    logic                return_from_irq_instr;        // pop, flag untouched
    logic                ext_branch; // branch form that extends execution
    logic                set_irq;    // write 1 to the accept flag
    logic                mask_irq;   // write 0 to the accept flag
    logic                arm_high;   // arm-on-high instruction
    logic                cps_set;
    logic                cps_clr;
    logic                s_write;
    logic                d_write;
    logic                skip;       // skip condition of this instruction
    logic                chain;      // chained skip condition
    logic [PC_W-1:0]     target;
    logic [S_PORT_W-1:0] s_data;
    logic [D_PORT_W-1:0] d_data;
  } core_cmd_t;
endpackage

/* File: hw/return_stack.sv */
/*
  Shift-register return stack of a few levels; level 0 is the top and is a register.
  Assumes push and pop come from one decoder and are not both meant at once.
*/
module return_stack #(
  parameter int unsigned W     = 13,
  parameter int unsigned DEPTH = 3
) (
  // clock and reset
  input  wire logic         clock,
  input  wire logic         nrst,
  // stack operations
  input  wire logic         push,
  input  wire logic         pop,
  input  wire logic [W-1:0] push_data,
  output logic      [W-1:0] top_data
);
  logic [W-1:0] level_reg  [DEPTH];
  logic [W-1:0] level_next [DEPTH];

  // a push beyond the depth drops the oldest level, as the silicon does
  always_comb begin
    for (int i = 0; i < DEPTH; i++) begin
      level_next[i] = level_reg[i];
    end
    if (push) begin
      level_next[0] = push_data;
      for (int i = 1; i < DEPTH; i++) begin
        level_next[i] = level_reg[i-1];
      end
    end else if (pop) begin
      for (int i = 0; i < DEPTH - 1; i++) begin
        level_next[i] = level_reg[i+1];
      end
    end
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      for (int i = 0; i < DEPTH; i++) begin
        level_reg[i] <= '0;
      end
    end else begin
      for (int i = 0; i < DEPTH; i++) begin
        level_reg[i] <= level_next[i];
      end
    end
  end

  assign top_data = level_reg[0];
endmodule // return_stack

/* File: hw/interrupt_and_reset_control.sv */
/*
  Interrupt acceptance, program counter with return stack and skip flags,
  and reset initialisation of a small 4-bit controller.
  Assumes the decoder drives one command word per clock and marks the last state of each machine cycle.
*/
module interrupt_and_reset_control #(
  parameter int unsigned HOLD_CYC = irq_reset_pkg::REF_HOLD_CYC
) (
  // clock and power-on reset
  input  wire logic                                  clock,
  input  wire logic                                  nrst,
  // external pins
  input  wire logic                                  irq_pin,
  input  wire logic                                  ref_high,
  // decoder commands
  input  wire irq_reset_pkg::core_cmd_t              cmd,
  // core state
  output logic        [irq_reset_pkg::PC_W-1:0]      pc_reg,
  output logic                                       irq_accept_flag,
  output logic                                       irq_taken_reg,
  output logic                                       skip_flag_reg,
  output logic                                       chain_flag_reg,
  output logic                                       pointer_carry_selector,
  output logic                                       core_reset_reg,
  // output ports
  output logic        [irq_reset_pkg::S_PORT_W-1:0]  s_port_reg,
  output logic        [irq_reset_pkg::D_PORT_W-1:0]  d_port_reg
);
  localparam int unsigned CNT_W = $clog2(HOLD_CYC + 2);
  localparam logic [CNT_W-1:0] HOLD_LIMIT = CNT_W'(HOLD_CYC);

  // request synchroniser and edge history
  logic irq_s1_reg, irq_s2_reg, irq_q_reg;
  logic irq_rise;

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      irq_s1_reg <= 1'h0;
      irq_s2_reg <= 1'h0;
      irq_q_reg  <= 1'h0;
    end else begin
      irq_s1_reg <= irq_pin;
      irq_s2_reg <= irq_s1_reg;
      irq_q_reg  <= irq_s2_reg;
    end
  end
  assign irq_rise = irq_s2_reg & ~irq_q_reg;

  // alternative reset: count while reference is high, hold core until it falls
  logic [CNT_W-1:0] ref_cnt_reg, ref_cnt_next;
  logic             core_reset_next;

  always_comb begin
    ref_cnt_next    = ref_cnt_reg;
    core_reset_next = core_reset_reg;
    if (!ref_high) begin
      ref_cnt_next    = '0;
      core_reset_next = 1'h0;     // start from address 0 on the fall
    end else if (ref_cnt_reg > HOLD_LIMIT) begin
      core_reset_next = 1'h1;     // strictly more than the hold time
    end else begin
      ref_cnt_next = ref_cnt_reg + CNT_W'(1);
    end
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      ref_cnt_reg    <= '0;
      core_reset_reg <= 1'h0;
    end else begin
      ref_cnt_reg    <= ref_cnt_next;
      core_reset_reg <= core_reset_next;
    end
  end

  // return stack
  irq_reset_pkg::stack_entry_t push_entry, top_entry;
  logic                        push, pop;

  return_stack #(
    .W     ($bits(irq_reset_pkg::stack_entry_t)),
    .DEPTH (irq_reset_pkg::STACK_DEPTH)
  ) u_stack (
    .clock     (clock),
    .nrst      (nrst),
    .push      (push),
    .pop       (pop),
    .push_data (push_entry),
    .top_data  (top_entry)
  );

  // core control state
  logic [irq_reset_pkg::PC_W-1:0]     pc_next;
  logic                               flag_next, arm_reg, arm_next, take;
  logic                               skip_next, chain_next, cps_next;
  logic [irq_reset_pkg::S_PORT_W-1:0] s_next;
  logic [irq_reset_pkg::D_PORT_W-1:0] d_next;
  logic                               pc_busy;

  // a boundary that already moves the pc defers the request by one instruction
  assign pc_busy = cmd.jump | cmd.call | cmd.ret | cmd.return_from_irq_instr | cmd.ext_branch;
  assign take    = cmd.boundary & irq_accept_flag & irq_s2_reg & ~pc_busy & ~core_reset_reg;

  always_comb begin
    pc_next    = pc_reg;
    flag_next  = irq_accept_flag;
    arm_next   = arm_reg;
    skip_next  = skip_flag_reg;
    chain_next = chain_flag_reg;
    cps_next   = pointer_carry_selector;
    s_next     = s_port_reg;
    d_next     = d_port_reg;
    push       = 1'h0;
    pop        = 1'h0;
    push_entry = '{pc: pc_reg, skip: skip_flag_reg, chain: chain_flag_reg};
    if (core_reset_reg) begin
      pc_next    = irq_reset_pkg::RESET_PC;
      flag_next  = irq_reset_pkg::RESET_FLAG;
      arm_next   = irq_reset_pkg::RESET_ARM;
      skip_next  = 1'h0;
      chain_next = 1'h0;
      cps_next   = irq_reset_pkg::RESET_CPS;
      s_next     = irq_reset_pkg::RESET_S;
      d_next     = irq_reset_pkg::RESET_D;
    end else begin
      // enable on a rising line once armed; a line held high never qualifies
      if (arm_reg && irq_rise) begin
        flag_next = 1'h1;
        arm_next  = 1'h0;
      end
      if (cmd.arm_high) begin
        arm_next = 1'h1;
      end
      if (cmd.set_irq) begin
        flag_next = 1'h1;
      end
      if (cmd.mask_irq) begin
        flag_next = 1'h0;
        arm_next  = 1'h0;
      end
      if (cmd.cps_set) begin
        cps_next = 1'h1;
      end else if (cmd.cps_clr) begin
        cps_next = 1'h0;
      end
      if (cmd.s_write) begin
        s_next = cmd.s_data;
      end
      if (cmd.d_write) begin
        d_next = cmd.d_data;
      end
      if (take) begin
        // entry stacks the unincremented address and the pending skips
        push       = 1'h1;
        pc_next    = irq_reset_pkg::IRQ_VECTOR;
        flag_next  = 1'h0;
        skip_next  = 1'h0;
        chain_next = 1'h0;
      end else if (cmd.boundary) begin
        skip_next  = cmd.skip;
        chain_next = cmd.chain;
        if (cmd.call) begin
          push    = 1'h1;
          pc_next = cmd.target;
          skip_next  = 1'h0;
          chain_next = 1'h0;
        end else if (cmd.ret || cmd.return_from_irq_instr) begin
          pop        = 1'h1;
          pc_next    = top_entry.pc;
          skip_next  = top_entry.skip;
          chain_next = top_entry.chain;
        end else if (cmd.jump) begin
          pc_next = cmd.target;
        end else if (cmd.inc_pc) begin
          // only the in-page word advances; it wraps inside the page
          pc_next[irq_reset_pkg::WORD_W-1:0] = pc_reg[irq_reset_pkg::WORD_W-1:0] + irq_reset_pkg::WORD_W'(1);
        end
      end
    end
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      pc_reg                 <= irq_reset_pkg::RESET_PC;
      irq_accept_flag        <= irq_reset_pkg::RESET_FLAG;
      arm_reg                <= irq_reset_pkg::RESET_ARM;
      irq_taken_reg          <= 1'h0;
      skip_flag_reg          <= 1'h0;
      chain_flag_reg         <= 1'h0;
      pointer_carry_selector <= irq_reset_pkg::RESET_CPS;
      s_port_reg             <= irq_reset_pkg::RESET_S;
      d_port_reg             <= irq_reset_pkg::RESET_D;
    end else begin
      pc_reg                 <= pc_next;
      irq_accept_flag        <= flag_next;
      arm_reg                <= arm_next;
      irq_taken_reg          <= take;
      skip_flag_reg          <= skip_next;
      chain_flag_reg         <= chain_next;
      pointer_carry_selector <= cps_next;
      s_port_reg             <= s_next;
      d_port_reg             <= d_next;
    end
  end

  // checks
  property p_entry_vector;
    @(posedge clock) disable iff (!nrst)
    take |=> (pc_reg == irq_reset_pkg::IRQ_VECTOR) && !irq_accept_flag && irq_taken_reg;
  endproperty
  a_entry_vector: assert property (p_entry_vector) else $error("entry missed vector or kept flag");

  property p_entry_push;
    @(posedge clock) disable iff (!nrst)
    take |=> (top_entry.pc == $past(pc_reg)) && (top_entry.skip == $past(skip_flag_reg));
  endproperty
  a_entry_push: assert property (p_entry_push) else $error("entry did not stack address and skip");

  property p_rti_keeps_off;
    @(posedge clock) disable iff (!nrst)
    (cmd.boundary && cmd.return_from_irq_instr && !irq_accept_flag && !cmd.set_irq && !arm_reg && !core_reset_reg)
      |=> !irq_accept_flag && (pc_reg == $past(top_entry.pc));
  endproperty
  a_rti_keeps_off: assert property (p_rti_keeps_off) else $error("return from interrupt altered flag");

  property p_high_not_enough;
    @(posedge clock) disable iff (!nrst)
    (arm_reg && !irq_accept_flag && irq_q_reg && !cmd.set_irq && !core_reset_reg) |=> !irq_accept_flag;
  endproperty
  a_high_not_enough: assert property (p_high_not_enough) else $error("enabled without low-then-high");

  property p_rise_enables;
    @(posedge clock) disable iff (!nrst)
    (arm_reg && irq_rise && !cmd.mask_irq && !cmd.arm_high && !take && !core_reset_reg)
      |=> irq_accept_flag && !arm_reg;
  endproperty
  a_rise_enables: assert property (p_rise_enables) else $error("armed rise did not enable");

  property p_skip_cleared;
    @(posedge clock) disable iff (!nrst)
    take |=> !skip_flag_reg && !chain_flag_reg && (top_entry.chain == $past(chain_flag_reg));
  endproperty
  a_skip_cleared: assert property (p_skip_cleared) else $error("skip flags not stacked on entry");

  property p_core_reset_init;
    @(posedge clock) disable iff (!nrst)
    core_reset_reg |=> (pc_reg == irq_reset_pkg::RESET_PC) && !irq_accept_flag && (s_port_reg == '0)
      && (d_port_reg == '0) && !pointer_carry_selector;
  endproperty
  a_core_reset_init: assert property (p_core_reset_init) else $error("reset state not reached");

  property p_ref_hold;
    @(posedge clock) disable iff (!nrst)
    (ref_high && (ref_cnt_reg > HOLD_LIMIT)) |=> core_reset_reg ##1 (!ref_high || core_reset_reg);
  endproperty
  a_ref_hold: assert property (p_ref_hold) else $error("long reference hold gave no reset");

  property p_boundary_only;
    @(posedge clock) disable iff (!nrst)
    irq_taken_reg |-> $past(cmd.boundary) && !$past(cmd.ext_branch) && $past(irq_s2_reg);
  endproperty
  a_boundary_only: assert property (p_boundary_only) else $error("entry off a boundary");
endmodule // interrupt_and_reset_control

/* File: verification/irq_ref_driver.sv */
/*
  Far-side model: interrupt request source and reference-input driver.
  Assumes the bench asks for levels and hold spans; pins move 1 ns after the rising edge.
*/
module irq_ref_driver (
  // clock
  input  wire logic        clock,
  // requests from the bench
  input  wire logic        irq_want,
  input  wire logic        ref_go,
  input  wire logic [15:0] ref_len,
  // pins towards the device
  output logic             irq_pin,
  output logic             ref_high
);
  timeunit 1ns;
  timeprecision 1ns;
  int unsigned left;
  logic        want_s;
  logic        go_s;
  initial begin
    irq_pin  = 1'h0;
    ref_high = 1'h0;
    left     = 0;
  end
  // requests sampled on the edge, pins moved just after it, so nothing races the bench
  always @(posedge clock) begin
    want_s = irq_want;
    go_s   = ref_go;
    #1;
    irq_pin = want_s;           // a level only; re-arming needs a low spell first
    if (go_s)
      left = ref_len;           // hold the reference input high for a set span
    else if (left != 0)
      left = left - 1;
    ref_high = (left != 0);
  end
endmodule // irq_ref_driver

/* File: verification/tb.sv */
/*
  Self-checking bench for the interrupt and reset control block, with an operation-level model.
  Assumes the far-side driver model and a shortened reference hold of 20 cycles.
*/
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic                                  clock;
  logic                                  nrst;
  logic                                  irq_want;
  logic                                  ref_go;
  logic [15:0]                           ref_len;
  logic                                  irq_pin;
  logic                                  ref_high;
  irq_reset_pkg::core_cmd_t              cmd;
  logic [irq_reset_pkg::PC_W-1:0]        pc_reg;
  logic                                  irq_accept_flag;
  logic                                  irq_taken_reg;
  logic                                  skip_flag_reg;
  logic                                  chain_flag_reg;
  logic                                  pointer_carry_selector;
  logic                                  core_reset_reg;
  logic [irq_reset_pkg::S_PORT_W-1:0]    s_port_reg;
  logic [irq_reset_pkg::D_PORT_W-1:0]    d_port_reg;
  int error_cnt, total_checks, taken_cnt, seed, i, t;
  int m_pc, m_flag, m_skip, m_chain, m_cps, m_s, m_d, m_armed, m_line, m_core, m_taken;
  int m_stk[$];

  irq_ref_driver far_u (.clock(clock), .irq_want(irq_want), .ref_go(ref_go), .ref_len(ref_len),
                        .irq_pin(irq_pin), .ref_high(ref_high));
  interrupt_and_reset_control #(.HOLD_CYC(20)) dut_u (
    .clock(clock), .nrst(nrst), .irq_pin(irq_pin), .ref_high(ref_high), .cmd(cmd),
    .pc_reg(pc_reg), .irq_accept_flag(irq_accept_flag), .irq_taken_reg(irq_taken_reg),
    .skip_flag_reg(skip_flag_reg), .chain_flag_reg(chain_flag_reg),
    .pointer_carry_selector(pointer_carry_selector), .core_reset_reg(core_reset_reg),
    .s_port_reg(s_port_reg), .d_port_reg(d_port_reg));

  // 10 MHz clock
  initial begin
    clock = 1'h0;
    forever #50 clock = ~clock;
  end
  // count entry pulses; a stuck pulse shows up as extra counts
  always @(posedge clock)
    if (irq_taken_reg === 1'h1) taken_cnt++;

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
    total_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("MISMATCH t=%0t %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask

  task automatic compare_all();
    chk(pc_reg, m_pc, "pc");
    chk(irq_accept_flag, m_flag, "accept flag");
    chk({skip_flag_reg, chain_flag_reg}, m_skip * 2 + m_chain, "skip");
    chk(pointer_carry_selector, m_cps, "selector");
    chk({s_port_reg, d_port_reg}, m_s * 2048 + m_d, "ports");
    chk(taken_cnt, m_taken, "entries");
    chk(core_reset_reg, m_core, "core reset");
  endtask

  task automatic model_reset();
    m_pc = 0;
    m_flag = 0;
    m_skip = 0;
    m_chain = 0;
    m_cps = 0;
    m_s = 0;
    m_d = 0;
    m_armed = 1;
    m_stk.delete();
  endtask

  // kinds: 0 inc, 1 jump, 2 rti, 3 extended branch, 4 set, 5 mask, 6 arm, 7 cps, 8 s, 9 d, 10 cps clear,
  // 11 call, 12 ret; the command stands for exactly one edge, as the boundary is a pulse
  task automatic step(input int kind, input int arg);
    irq_reset_pkg::core_cmd_t c;
    int enter;
    c = '0;
    enter = m_flag && m_line && (kind == 0);
    c.boundary = (kind <= 3) || (kind >= 11);
    c.call = (kind == 11);
    c.ret = (kind == 12);
    c.inc_pc = (kind == 0) || (kind == 3);
    c.jump = (kind == 1);
    c.return_from_irq_instr = (kind == 2);
    c.ext_branch = (kind == 3);
    c.set_irq = (kind == 4);
    c.mask_irq = (kind == 5);
    c.arm_high = (kind == 6);
    c.cps_set = (kind == 7);
    c.s_write = (kind == 8);
    c.d_write = (kind == 9);
    c.cps_clr = (kind == 10);
    c.skip = arg[12];
    c.chain = arg[13];
    c.target = arg[10:0];
    c.s_data = arg[7:0];
    c.d_data = arg[10:0];
    cmd = c;
    @(posedge clock);
    #1;
    cmd = '0;
    @(posedge clock);
    #1;
    if (enter) begin
      m_stk.push_front(m_pc * 4 + m_skip * 2 + m_chain);
      if (m_stk.size() > 3) void'(m_stk.pop_back());
      m_pc = 'h300;
      m_flag = 0;
      m_skip = 0;
      m_chain = 0;
      m_taken++;
    end else if (kind == 0 || kind == 3) begin
      m_pc = (m_pc & 'h7c0) | ((m_pc + 1) & 'h3f);
      m_skip = arg[12];
      m_chain = arg[13];
    end else if (kind == 1) begin
      m_pc = arg & 'h7ff;
      m_skip = arg[12];
      m_chain = arg[13];
    end else if (kind == 11) begin
      m_stk.push_front(m_pc * 4 + m_skip * 2 + m_chain);
      if (m_stk.size() > 3) void'(m_stk.pop_back());
      m_pc = arg & 'h7ff;
      m_skip = 0;
      m_chain = 0;
    end else if (kind == 2 || kind == 12) begin
      t = m_stk.pop_front();
      m_pc = t >> 2;
      m_skip = t[1];
      m_chain = t[0];
    end
    if (kind == 4) m_flag = 1;
    if (kind == 5) m_flag = 0;
    if (kind == 5) m_armed = 0;
    if (kind == 6) m_armed = 1;
    if (kind == 7) m_cps = 1;
    if (kind == 10) m_cps = 0;
    if (kind == 8) m_s = arg & 'hff;
    if (kind == 9) m_d = arg & 'h7ff;
    compare_all();
  endtask

  task automatic set_line(input int v);
    irq_want = v[0];
    repeat (5) @(posedge clock);
    #1;
    if (v && !m_line && m_armed) begin
      m_flag = 1;
      m_armed = 0;
    end
    m_line = v;
    compare_all();
  endtask

  task automatic finish_test();
    $display("checks %0d mismatches %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  // watchdog far beyond the few hundred cycles the sequence needs
  initial begin
    #2000000;
    error_cnt++;
    finish_test();
  end

  // main sequence
  initial begin
    seed = 53;
    error_cnt = 0;
    total_checks = 0;
    taken_cnt = 0;
    m_taken = 0;
    m_line = 0;
    m_core = 0;
    cmd = '0;
    irq_want = 1'h0;
    ref_go = 1'h0;
    ref_len = 16'h0000;
    nrst = 1'h0;
    repeat (10) @(posedge clock);
    #1;
    nrst = 1'h1;
    model_reset();
    compare_all();
    step(1, $random(seed) & 'h7ff);
    step(0, 'h3000);
    set_line(1);
    step(0, 0);
    step(0, 0);
    step(2, 0);
    step(1, 'h07f);
    step(0, 0);
    step(6, 0);
    repeat (6) @(posedge clock);
    #1;
    compare_all();
    set_line(0);
    set_line(1);
    step(3, 0);
    step(0, 0);
    step(2, 0);
    step(4, 0);
    step(5, 0);
    // calls stack the pending skips and clear them; returns bring them back
    step(0, 'h3000);
    step(11, 'h1a5);
    step(11, 'h2c3);
    step(12, 0);
    step(12, 0);
    for (i = 0; i < 8; i++) begin
      step(7 + (($random(seed) & 'h7fffffff) % 4), $random(seed) & 'h7ff);
      step(1, $random(seed) & 'h7ff);
      step(0, 0);
    end
    set_line(0);
    step(8, 'h5a);
    step(7, 0);
    ref_len = 16'h000a;
    ref_go = 1'h1;
    @(posedge clock);
    #1;
    ref_go = 1'h0;
    repeat (15) @(posedge clock);
    #1;
    compare_all();
    ref_len = 16'h0028;
    ref_go = 1'h1;
    @(posedge clock);
    #1;
    ref_go = 1'h0;
    for (i = 0; i < 60 && core_reset_reg !== 1'h1; i++) begin
      @(posedge clock);
      #1;
    end
    // the reset values are reloaded on the edge after the hold flag rises
    @(posedge clock);
    #1;
    m_core = 1;
    model_reset();
    compare_all();
    for (i = 0; i < 80 && core_reset_reg !== 1'h0; i++) begin
      @(posedge clock);
      #1;
    end
    m_core = 0;
    compare_all();
    set_line(1);
    step(0, 0);
    set_line(0);
    step(9, 'h7ff);
    step(8, 'hff);
    step(7, 0);
    nrst = 1'h0;
    repeat (2) @(posedge clock);
    #1;
    nrst = 1'h1;
    model_reset();
    compare_all();
    finish_test();
  end
endmodule // tb
